/* verilog/lpm_defines.svh */
// How it works
// RULE1 - enable low means shutdown; LED current stays off until enable returns
// RULE2 - while enabled, LED current follows the dimming input level
// RULE3 - supply follows enable; LEDs lit only with enable, dimming high, flag released
// RULE4 - a floating dimming input reads low, so LEDs stay off
// RULE5 - on-time and duty supervised always; a violation pulls flag and kills current; code checks duty only after a fall since enable
// RULE6 - high phase beyond on-time limit flags fault for rest of cycle
// RULE7 - on-time fault clears at next rising edge, repeats each violating cycle
// RULE8 - at rising edge, low phase shorter than blanking time raises duty fault; code checks only once a fall is seen after enable
// RULE9 - duty fault holds current off at least blanking time, clears at later rise
// RULE10 - duty fault pulls the active-low fault flag while active
// RULE11 - within limits no fault: LED tracks dimming input, flag stays released
// RULE12 - controller keeps high phases beyond mask time when LED faults matter
// RULE13 - high phases as short as 5 us still switch LED current on
// RULE14 - on-time limit spans 0.250 ms to 5.00 ms
// RULE15 - blanking limit spans 0.82 ms to 19 ms
// RULE16 - duty fault after on-time fault clears at fall of next good pulse
// RULE17 - on-time restarts at rise, off-time at fall, counted on internal time base
// RULE18 - disable resets counters and fault state; flag starts released
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define LPM_ADDR_STATUS 8'h00
`define LPM_ADDR_ON_LIMIT 8'h04
`define LPM_ADDR_DUTY_LIMIT 8'h08
`define LPM_ADDR_IRQ_STAT 8'h0c
`define LPM_ADDR_IRQ_MASK 8'h10

// ----------------------------------------
// status field positions
// ----------------------------------------
`define LPM_ST_STATE_LSB 0
`define LPM_ST_PULL_BIT 5
`define LPM_ST_PWM_BIT 6
`define LPM_ST_EN_BIT 7
`define LPM_ST_PIN_BIT 8

// ----------------------------------------
// timing, limits in microseconds
// ----------------------------------------
`define LPM_CLK_NS 5
`define LPM_TICK_NS 1000
`define LPM_TICK_CYC (`LPM_TICK_NS / `LPM_CLK_NS)
`define LPM_PWM_MIN_ON_US 5
`define LPM_ON_MIN_US 16'h00fa
`define LPM_ON_MAX_US 16'h1388
`define LPM_BLANK_MIN_US 16'h0334
`define LPM_BLANK_MAX_US 16'h4a38
`define LPM_ON_RESET 16'h03e8
`define LPM_BLANK_RESET 16'h03e8
`define LPM_MASK_RESET 3'h0

`endif

/* verilog/lpm_pkg.sv */
package lpm_pkg;

  // monitor states, one-hot
  typedef enum logic [4:0] {
    ST_SHDN = 5'h01,
    ST_NORM = 5'h02,
    ST_ON_TIME_LIMIT = 5'h04,
    ST_DUTY_CYCLE_LIMIT = 5'h08,
    ST_BOTH = 5'h10
  } lpm_state_t;

  // interrupt events, same layout for status and mask
  typedef struct packed {
    logic clr;
    logic duty;
    logic ton;
  } lpm_evt_t;

endpackage

/* verilog/lpm_timer.sv */
`timescale 1ns/10ps
// saturating phase timer on the microsecond time base
module lpm_timer
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clr,
  input wire logic i_run,
  input wire logic i_tick,
  output logic [15:0] o_cnt
);

  wire logic sat;
  assign sat = (o_cnt == 16'hffff);

  // clear wins, then count ticks while running
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cnt <= 16'h0000;
    else if (i_clr)
      o_cnt <= 16'h0000;
    else if (i_run && i_tick && !sat)
      o_cnt <= o_cnt + 16'h0001;
  end

  property p_tmr_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_clr |=> o_cnt == 16'h0000;
  endproperty
  a_tmr_clear: assert property (p_tmr_clear) else $error("timer not cleared"); // RULE17

  property p_tmr_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_clr && !i_run |=> $stable(o_cnt);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer moved while stopped"); // RULE17

endmodule

/* verilog/lpm_monitor.sv */
`timescale 1ns/10ps
`include "lpm_defines.svh"
// dimming gate and pulse monitor for the LED current stage
module lpm_monitor
(
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_EN,
  input wire logic I_PWM,
  input wire logic I_FAULT_FLAG_N,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_IRQ,
  output logic O_SUPPLY_ON,
  output logic O_LED_ON,
  output logic O_FAULT_FLAG_N,
  output logic O_FAULT_FLAG_OE
);

  // ----------------------------------------
  // time base
  // ----------------------------------------
  logic [7:0] div_cnt;
  logic tick;
  wire logic div_end;
  assign div_end = (div_cnt == 8'(`LPM_TICK_CYC - 1));

  // one microsecond enable pulse, held at zero in shutdown
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      div_cnt <= (div_end || !I_EN) ? 8'h00 : div_cnt + 8'h01;
      tick <= div_end && I_EN;
    end
  end

  // ----------------------------------------
  // dimming input edges
  // ----------------------------------------
  logic pwm_q;
  logic seen_fall;
  wire logic pwm_in;
  wire logic rise;
  wire logic fall;
  assign pwm_in = I_EN & I_PWM; // RULE4
  assign rise = pwm_in & ~pwm_q;
  assign fall = ~pwm_in & pwm_q;

  // previous level and first-fall marker, both dropped in shutdown
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pwm_q <= 1'b0;
      seen_fall <= 1'b0;
    end
    else
    begin
      pwm_q <= pwm_in;
      seen_fall <= I_EN & (seen_fall | fall); // RULE18
    end
  end

  // ----------------------------------------
  // phase timers
  // ----------------------------------------
  logic [15:0] on_cnt;
  logic [15:0] off_cnt;
  logic [15:0] blank_cnt;
  wire logic duty_cycle_limit_enter;

  // on-time restarts at rise, off-time at fall
  lpm_timer u_on_tmr
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_clr(!I_EN || rise), // RULE17
    .i_run(pwm_q),
    .i_tick(tick),
    .o_cnt(on_cnt)
  );

  lpm_timer u_off_tmr
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_clr(!I_EN || fall), // RULE17
    .i_run(!pwm_q),
    .i_tick(tick),
    .o_cnt(off_cnt)
  );

  // blanking interval after a duty fault is raised
  lpm_timer u_blank_tmr
  (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_clr(!I_EN || duty_cycle_limit_enter), // RULE9
    .i_run(1'b1),
    .i_tick(tick),
    .o_cnt(blank_cnt)
  );

  // ----------------------------------------
  // limit registers
  // ----------------------------------------
  logic [15:0] on_lim;
  logic [15:0] blank_lim;
  wire logic [15:0] wr_val;
  wire logic [15:0] on_clamp;
  wire logic [15:0] blank_clamp;
  assign wr_val = I_WDATA[15:0];
  assign on_clamp = (wr_val < `LPM_ON_MIN_US) ? `LPM_ON_MIN_US : // RULE14
    (wr_val > `LPM_ON_MAX_US) ? `LPM_ON_MAX_US : wr_val;
  assign blank_clamp = (wr_val < `LPM_BLANK_MIN_US) ? `LPM_BLANK_MIN_US : // RULE15
    (wr_val > `LPM_BLANK_MAX_US) ? `LPM_BLANK_MAX_US : wr_val;

  // ----------------------------------------
  // fault comparisons
  // ----------------------------------------
  wire logic ton_over;
  wire logic short_off;
  wire logic blank_done;
  assign ton_over = pwm_q & pwm_in & (on_cnt > on_lim); // RULE6
  assign short_off = seen_fall & (off_cnt < blank_lim); // RULE8
  assign blank_done = (blank_cnt >= blank_lim); // RULE9

  // ----------------------------------------
  // monitor state machine
  // ----------------------------------------
  lpm_pkg::lpm_state_t state;
  lpm_pkg::lpm_state_t next_state;
  logic armed;
  logic next_armed;

  always_comb
  begin
    next_state = state;
    next_armed = armed;
    case (state)
      lpm_pkg::ST_SHDN:
        next_state = lpm_pkg::ST_NORM;
      lpm_pkg::ST_NORM:
        if (rise && short_off)
          next_state = lpm_pkg::ST_DUTY_CYCLE_LIMIT; // RULE8
        else if (ton_over)
          next_state = lpm_pkg::ST_ON_TIME_LIMIT; // RULE6
      lpm_pkg::ST_ON_TIME_LIMIT:
        if (rise)
          next_state = short_off ? lpm_pkg::ST_BOTH : lpm_pkg::ST_NORM; // RULE7
      lpm_pkg::ST_DUTY_CYCLE_LIMIT:
        if (rise && blank_done)
          next_state = lpm_pkg::ST_NORM; // RULE9
      lpm_pkg::ST_BOTH:
      begin
        if (rise)
          next_armed = blank_done;
        else if (ton_over)
          next_armed = 1'b0;
        if (fall && armed)
          next_state = lpm_pkg::ST_NORM; // RULE16
      end
      default:
        next_state = lpm_pkg::ST_SHDN;
    endcase
    if (next_state != lpm_pkg::ST_BOTH)
      next_armed = 1'b0;
    if (!I_EN)
      next_state = lpm_pkg::ST_SHDN; // RULE1
  end

  assign duty_cycle_limit_enter = I_EN && rise && short_off &&
    (state == lpm_pkg::ST_NORM || state == lpm_pkg::ST_ON_TIME_LIMIT);

  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= lpm_pkg::ST_SHDN;
      armed <= 1'b0;
    end
    else
    begin
      state <= next_state; // RULE18
      armed <= next_armed;
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  wire logic next_fault;
  assign next_fault = (next_state != lpm_pkg::ST_NORM) && (next_state != lpm_pkg::ST_SHDN);

  // current gate and open-drain flag, all registered
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      O_SUPPLY_ON <= 1'b0;
      O_LED_ON <= 1'b0;
      O_FAULT_FLAG_N <= 1'b0;
      O_FAULT_FLAG_OE <= 1'b0;
    end
    else
    begin
      O_SUPPLY_ON <= I_EN; // RULE3
      O_FAULT_FLAG_N <= 1'b0; // pin data stays low, only the enable moves
      O_LED_ON <= pwm_in && (next_state == lpm_pkg::ST_NORM); // RULE2 RULE11 RULE13
      O_FAULT_FLAG_OE <= next_fault; // RULE5 RULE10
    end
  end

  // ----------------------------------------
  // register bus and interrupts
  // ----------------------------------------
  lpm_pkg::lpm_evt_t irq_stat;
  lpm_pkg::lpm_evt_t irq_mask;
  lpm_pkg::lpm_evt_t evt;
  wire logic sel_status;
  wire logic sel_on;
  wire logic sel_duty;
  wire logic sel_istat;
  wire logic sel_imask;
  wire logic [31:0] status_word;
  wire logic [31:0] rd_mux;
  assign sel_status = (I_ADDR == `LPM_ADDR_STATUS);
  assign sel_on = (I_ADDR == `LPM_ADDR_ON_LIMIT);
  assign sel_duty = (I_ADDR == `LPM_ADDR_DUTY_LIMIT);
  assign sel_istat = (I_ADDR == `LPM_ADDR_IRQ_STAT);
  assign sel_imask = (I_ADDR == `LPM_ADDR_IRQ_MASK);
  assign evt = {(state != lpm_pkg::ST_NORM) && (state != lpm_pkg::ST_SHDN) &&
    (next_state == lpm_pkg::ST_NORM), duty_cycle_limit_enter,
    (next_state == lpm_pkg::ST_ON_TIME_LIMIT) && (state != lpm_pkg::ST_ON_TIME_LIMIT)};
  assign status_word = {23'h000000, I_FAULT_FLAG_N, I_EN, pwm_q,
    O_FAULT_FLAG_OE, 5'(state)};
  assign rd_mux = sel_status ? status_word :
    sel_on ? {16'h0000, on_lim} :
    sel_duty ? {16'h0000, blank_lim} :
    sel_istat ? {29'h00000000, irq_stat} :
    sel_imask ? {29'h00000000, irq_mask} : 32'h00000000;

  // writes, read data for one cycle, sticky status cleared by its read
  always_ff @(posedge I_MCLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      on_lim <= `LPM_ON_RESET;
      blank_lim <= `LPM_BLANK_RESET;
      irq_mask <= `LPM_MASK_RESET;
      irq_stat <= 3'h0;
      O_RDATA <= 32'h00000000;
      O_IRQ <= 1'b0;
    end
    else
    begin
      if (I_WR && sel_on)
        on_lim <= on_clamp;
      if (I_WR && sel_duty)
        blank_lim <= blank_clamp;
      if (I_WR && sel_imask)
        irq_mask <= I_WDATA[2:0];
      irq_stat <= ((I_RD && sel_istat) ? 3'h0 : irq_stat) | evt; // set wins
      O_RDATA <= I_RD ? rd_mux : 32'h00000000;
      O_IRQ <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  wire logic in_fault;
  assign in_fault = (state != lpm_pkg::ST_NORM) && (state != lpm_pkg::ST_SHDN);

  property p_shdn;
    !I_EN |=> !O_LED_ON && !O_FAULT_FLAG_OE && state == lpm_pkg::ST_SHDN;
  endproperty
  a_shdn: assert property (p_shdn) else $error("led on while disabled"); // RULE1

  property p_pwm_low;
    !I_PWM |=> !O_LED_ON;
  endproperty
  a_pwm_low: assert property (p_pwm_low) else $error("led on with input low"); // RULE2

  property p_led_flag;
    O_LED_ON |-> !O_FAULT_FLAG_OE && O_SUPPLY_ON;
  endproperty
  a_led_flag: assert property (p_led_flag) else $error("led on with flag pulled"); // RULE3

  property p_flag_follow;
    in_fault |-> O_FAULT_FLAG_OE && !O_LED_ON;
  endproperty
  a_flag_follow: assert property (p_flag_follow) else $error("fault not shown"); // RULE5

  property p_ton;
    I_EN && state == lpm_pkg::ST_NORM && ton_over |=> state == lpm_pkg::ST_ON_TIME_LIMIT;
  endproperty
  a_ton: assert property (p_ton) else $error("on-time fault missed"); // RULE6

  property p_on_time_limit_clear;
    I_EN && state == lpm_pkg::ST_ON_TIME_LIMIT && rise && !short_off |=> state == lpm_pkg::ST_NORM;
  endproperty
  a_on_time_limit_clear: assert property (p_on_time_limit_clear) else $error("on-time fault kept"); // RULE7

  property p_duty;
    I_EN && state == lpm_pkg::ST_NORM && rise && short_off |=> state == lpm_pkg::ST_DUTY_CYCLE_LIMIT;
  endproperty
  a_duty: assert property (p_duty) else $error("duty fault missed"); // RULE8

  property p_duty_cycle_limit_hold;
    I_EN && state == lpm_pkg::ST_DUTY_CYCLE_LIMIT && !blank_done |=> state == lpm_pkg::ST_DUTY_CYCLE_LIMIT;
  endproperty
  a_duty_cycle_limit_hold: assert property (p_duty_cycle_limit_hold) else $error("duty fault left early"); // RULE9

  property p_duty_cycle_limit_flag;
    state == lpm_pkg::ST_DUTY_CYCLE_LIMIT |-> O_FAULT_FLAG_OE && !O_FAULT_FLAG_N && !O_LED_ON;
  endproperty
  a_duty_cycle_limit_flag: assert property (p_duty_cycle_limit_flag) else $error("flag not pulled"); // RULE10

  property p_normal;
    I_EN && I_PWM && state == lpm_pkg::ST_NORM && !ton_over && !(rise && short_off)
      |=> O_LED_ON && !O_FAULT_FLAG_OE;
  endproperty
  a_normal: assert property (p_normal) else $error("led not tracking input"); // RULE11 RULE13

  property p_limits;
    on_lim >= `LPM_ON_MIN_US && on_lim <= `LPM_ON_MAX_US &&
      blank_lim >= `LPM_BLANK_MIN_US && blank_lim <= `LPM_BLANK_MAX_US;
  endproperty
  a_limits: assert property (p_limits) else $error("limit out of range"); // RULE14 RULE15

  property p_both_clear;
    I_EN && state == lpm_pkg::ST_BOTH && fall && armed |=> state == lpm_pkg::ST_NORM;
  endproperty
  a_both_clear: assert property (p_both_clear) else $error("double fault kept"); // RULE16

  property p_disable_reset;
    !I_EN |=> on_cnt == 16'h0000 && off_cnt == 16'h0000 && !seen_fall;
  endproperty
  a_disable_reset: assert property (p_disable_reset) else $error("state kept"); // RULE18

  property p_irq;
    |(irq_stat & irq_mask) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_on_time_limit: cover property (state == lpm_pkg::ST_ON_TIME_LIMIT ##[1:1000] state == lpm_pkg::ST_NORM);
  c_duty_cycle_limit: cover property (state == lpm_pkg::ST_DUTY_CYCLE_LIMIT ##1 state == lpm_pkg::ST_DUTY_CYCLE_LIMIT);
  c_both: cover property (state == lpm_pkg::ST_BOTH ##1 state == lpm_pkg::ST_NORM);
  c_short: cover property (fall && O_LED_ON && on_cnt == 16'(`LPM_PWM_MIN_ON_US));

endmodule

/* test/lpm_ctrl_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// controller model: drives enable and dimming, resolves the flag wire
// ----------------------------------------
module lpm_ctrl_model
(
  input wire logic i_clk,
  input wire logic i_flag_n,
  input wire logic i_flag_oe,
  output logic o_en,
  output logic o_pwm,
  output logic o_flag_wire
);
  // open-drain wire with pull-up: low only while the device pulls it
  assign o_flag_wire = i_flag_oe ? i_flag_n : 1'b1;

  // idle dimming line sits low, as the pulled-down pin would read
  initial
  begin
    o_en = 1'b0;
    o_pwm = 1'b0;
  end

  // hold both levels for n cycles; changes land just after an edge
  // high phase length is set by n; the on-time test holds 249 us, one short of the 250 us limit
  task drive(input logic en, input logic pwm, input int n);
    o_en <= en;
    o_pwm <= pwm;
    repeat (n) @(posedge i_clk);
  endtask
endmodule

/* test/lpm_monitor_tb.sv */
`timescale 1ns/10ps
`include "lpm_defines.svh"
module lpm_monitor_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] rdata;
  logic irq, supply_on, led_on, flag_n, flag_oe, en, pwm, flag_wire;
  logic [31:0] exp_q[$];
  logic [15:0] r;
  logic [15:0] r_exp;
  int n_mismatch = 0;
  int tests_run = 0;
  int k;

  always #2.5 mclk = ~mclk;

  // ----------------------------------------
  // design and controller model
  // ----------------------------------------
  lpm_monitor i_lpm_monitor
  (
    .I_MCLK(mclk),
    .I_RST_N(rst_n),
    .I_EN(en),
    .I_PWM(pwm),
    .I_FAULT_FLAG_N(flag_wire),
    .I_ADDR(addr),
    .I_WDATA(wdata),
    .I_WR(wr),
    .I_RD(rd),
    .O_RDATA(rdata),
    .O_IRQ(irq),
    .O_SUPPLY_ON(supply_on),
    .O_LED_ON(led_on),
    .O_FAULT_FLAG_N(flag_n),
    .O_FAULT_FLAG_OE(flag_oe)
  );

  lpm_ctrl_model i_lpm_ctrl_model
  (
    .i_clk(mclk),
    .i_flag_n(flag_n),
    .i_flag_oe(flag_oe),
    .o_en(en),
    .o_pwm(pwm),
    .o_flag_wire(flag_wire)
  );

  // ----------------------------------------
  // compare, bus tasks, verdict
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  // note the expected word, then issue the one-cycle read
  task bus_rd(input logic [7:0] a, input logic [31:0] d);
    exp_q.push_back(d);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  // read data stand only in the cycle after the read edge
  always @(posedge mclk)
    rd_seen <= rd;

  always @(negedge mclk)
    if (rd_seen)
      check("rdata", rdata, exp_q.pop_front());

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(713));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    // limits, clamping, mask, unmapped address
    bus_rd(`LPM_ADDR_ON_LIMIT, 32'h3e8);
    bus_rd(`LPM_ADDR_DUTY_LIMIT, 32'h3e8);
    bus_rd(`LPM_ADDR_IRQ_MASK, 32'h0);
    bus_rd(8'h14, 32'h0);
    bus_wr(`LPM_ADDR_ON_LIMIT, 32'h0);
    bus_rd(`LPM_ADDR_ON_LIMIT, 32'hfa);
    bus_wr(`LPM_ADDR_DUTY_LIMIT, 32'hffff);
    bus_rd(`LPM_ADDR_DUTY_LIMIT, 32'h4a38);
    bus_wr(`LPM_ADDR_DUTY_LIMIT, 32'h0);
    bus_rd(`LPM_ADDR_DUTY_LIMIT, 32'h334);
    r = 16'($urandom_range(0, 16'hffff));
    r_exp = (r < `LPM_ON_MIN_US) ? `LPM_ON_MIN_US : ((r > `LPM_ON_MAX_US) ? `LPM_ON_MAX_US : r);
    bus_wr(`LPM_ADDR_ON_LIMIT, {16'h0, r});
    bus_rd(`LPM_ADDR_ON_LIMIT, {16'h0, r_exp});
    bus_wr(`LPM_ADDR_ON_LIMIT, 32'hfa);
    bus_wr(`LPM_ADDR_IRQ_MASK, 32'h7);
    $display("test registers done");
    // shutdown ignores a high dimming input
    i_lpm_ctrl_model.drive(1'b0, 1'b1, 4);
    @(negedge mclk);
    check("supply", supply_on, 32'h0);
    check("led", led_on, 32'h0);
    check("flag_oe", flag_oe, 32'h0);
    $display("test shutdown done");
    @(posedge mclk);
    // enabled, short legal pulse lights the LED
    i_lpm_ctrl_model.drive(1'b1, 1'b0, 4);
    @(negedge mclk);
    check("supply", supply_on, 32'h1);
    check("led", led_on, 32'h0);
    @(posedge mclk);
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 1000 + $urandom_range(0, 200));
    @(negedge mclk);
    check("led", led_on, 32'h1);
    check("flag_oe", flag_oe, 32'h0);
    @(posedge mclk);
    i_lpm_ctrl_model.drive(1'b1, 1'b0, 10);
    @(negedge mclk);
    check("led", led_on, 32'h0);
    @(posedge mclk);
    $display("test normal done");
    // short low phase then a rise: duty fault
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 4);
    @(negedge mclk);
    check("flag_oe", flag_oe, 32'h1);
    check("flag_wire", flag_wire, 32'h0);
    check("flag_n", flag_n, 32'h0);
    check("led", led_on, 32'h0);
    check("irq", irq, 32'h1);
    @(posedge mclk);
    bus_rd(`LPM_ADDR_STATUS, 32'he8);
    bus_rd(`LPM_ADDR_IRQ_STAT, 32'h2);
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 3);
    @(negedge mclk);
    check("irq", irq, 32'h0);
    @(posedge mclk);
    bus_wr(`LPM_ADDR_IRQ_MASK, 32'h0);
    $display("test duty done");
    // disable clears the fault
    i_lpm_ctrl_model.drive(1'b0, 1'b0, 4);
    @(negedge mclk);
    check("flag_oe", flag_oe, 32'h0);
    check("supply", supply_on, 32'h0);
    $display("test disable done");
    @(posedge mclk);
    // long high phase: on-time fault just past 250 us
    i_lpm_ctrl_model.drive(1'b1, 1'b0, 4);
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 249 * `LPM_TICK_CYC);
    @(negedge mclk);
    check("led", led_on, 32'h1);
    check("flag_oe", flag_oe, 32'h0);
    @(posedge mclk);
    for (k = 0; k < 5 * `LPM_TICK_CYC && flag_oe !== 1'b1; k++)
      @(posedge mclk);
    if (k == 5 * `LPM_TICK_CYC)
      check("flag_oe_wait", flag_oe, 32'h1);
    @(negedge mclk);
    check("led", led_on, 32'h0);
    check("irq", irq, 32'h0);
    @(posedge mclk);
    bus_wr(`LPM_ADDR_IRQ_MASK, 32'h1);
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 3);
    @(negedge mclk);
    check("irq", irq, 32'h1);
    @(posedge mclk);
    // short low after the on-time fault: rise leads to double fault
    i_lpm_ctrl_model.drive(1'b1, 1'b0, 10);
    i_lpm_ctrl_model.drive(1'b1, 1'b1, 4);
    bus_rd(`LPM_ADDR_STATUS, 32'hf0);
    @(negedge mclk);
    check("led", led_on, 32'h0);
    @(posedge mclk);
    $display("test on_time done");
    repeat (4) @(posedge mclk);
    final_report();
  end
endmodule
